/* logic/sr_defines.svh */
/*
 * Register offsets, bit positions, sample numbers and reset values
 * of the serial receive block. Assumes byte addresses on AHB-Lite.
 */
`ifndef SR_DEFINES_SVH
`define SR_DEFINES_SVH
`define SR_OFS_STATUS 8'h00
`define SR_OFS_DATA 8'h04
`define SR_OFS_CTRL1 8'h08
`define SR_OFS_CTRL2 8'h0C
`define SR_OFS_BAUD 8'h10
`define SR_OFS_RXFINE 8'h14
`define SR_OFS_TXFINE 8'h18
`define SR_C1_NINTH 7
`define SR_C1_TXNINTH 6
`define SR_C1_WORD9 4
`define SR_C1_WAKE 3
`define SR_C1_PARON 2
`define SR_C1_PARODD 1
`define SR_C1_PIE 0
`define SR_C2_RIE 5
`define SR_C2_IDLE_IRQ_EN 4
`define SR_C2_TE 3
`define SR_C2_RE 2
`define SR_C2_MUTE 1
`define SR_ST_FULL 5
`define SR_ST_IDLE 4
`define SR_ST_OVR 3
`define SR_ST_NOISE 2
`define SR_ST_FRAME 1
`define SR_ST_PAR 0
`define SR_SMP_FIRST 5'd2
`define SR_SMP_3 5'd3
`define SR_SMP_5 5'd5
`define SR_SMP_7 5'd7
`define SR_SMP_8 5'd8
`define SR_SMP_9 5'd9
`define SR_SMP_10 5'd10
`define SR_SMP_LAST 5'd16
`define SR_IDLE_LIM8 8'd160
`define SR_IDLE_LIM9 8'd176
`define SR_LAST_BIT8 4'd7
`define SR_LAST_BIT9 4'd8
`define SR_PR_SEL0 4'd1
`define SR_PR_SEL1 4'd3
`define SR_PR_SEL2 4'd4
`define SR_PR_SEL3 4'd13
`define SR_RST_BYTE 8'h00
`endif

/* logic/sr_pkg.sv */
/*
 * Types of the serial receive block.
 * Assumes nothing of its surroundings.
 */
package sr_pkg;
    typedef enum logic [1:0] {
        SR_HUNT,
        SR_START,
        SR_DATA,
        SR_STOP
    } sr_state_e;
endpackage

/* logic/sr_async_receiver.sv */
/*
 * Receive path of an asynchronous serial port with both baud generators,
 * an AHB-Lite register slave and the transmit word preparation.
 * Assumes one clock, zero-wait single word transfers and a remote
 * transmitter driving serialInPin.
 */
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sr_defines.svh"

module sr_async_receiver import sr_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // serial line
    input wire logic serialInPin,
    // cpu interrupt mask bit and request
    input wire logic cpuIrqMask,
    output logic rxIrq,
    // transmitter side
    output logic txEnable,
    output logic txTick,
    output logic [8:0] txWord,
    output logic txLoad
);
    // bus slave
    logic wrPendQ;
    logic [7:0] wrAddrQ;
    logic [31:0] hrdataQ;
    logic hreadyQ;
    logic statusSeenQ;
    logic [7:0] ctrl1Q;
    logic [7:0] ctrl2Q;
    logic [7:0] baudQ;
    logic [7:0] fineQ [2];
    logic muteQ;
    logic ninthQ;
    logic [7:0] bufQ;
    logic [5:0] flagsQ;
    logic irqQ;
    logic [8:0] txWordQ;
    logic txLoadQ;

    wire [7:0] ofs = haddr[7:0];
    wire acc = hsel && htrans[1] && hready;
    wire rdAcc = acc && !hwrite;
    wire accStatus = acc && ofs == `SR_OFS_STATUS;
    wire rdData = rdAcc && ofs == `SR_OFS_DATA;
    wire clrSeq = rdData && statusSeenQ;
    wire wrData = wrPendQ && wrAddrQ == `SR_OFS_DATA;
    wire wrCtrl1 = wrPendQ && wrAddrQ == `SR_OFS_CTRL1;
    wire wrCtrl2 = wrPendQ && wrAddrQ == `SR_OFS_CTRL2;
    wire wrBaud = wrPendQ && wrAddrQ == `SR_OFS_BAUD;
    wire wrRxFine = wrPendQ && wrAddrQ == `SR_OFS_RXFINE;
    wire wrTxFine = wrPendQ && wrAddrQ == `SR_OFS_TXFINE;

    wire word9 = ctrl1Q[`SR_C1_WORD9];
    wire parOn = ctrl1Q[`SR_C1_PARON];
    wire parOdd = ctrl1Q[`SR_C1_PARODD];
    wire wakeSel = ctrl1Q[`SR_C1_WAKE];
    wire reEn = ctrl2Q[`SR_C2_RE];

    wire [7:0] ctrl1Rd = {ninthQ, ctrl1Q[6:0]};
    wire [7:0] ctrl2Rd = {ctrl2Q[7:2], muteQ, ctrl2Q[0]};
    wire [7:0] rdByte =
        ofs == `SR_OFS_STATUS ? {2'b00, flagsQ} :
        ofs == `SR_OFS_DATA ? bufQ :
        ofs == `SR_OFS_CTRL1 ? ctrl1Rd :
        ofs == `SR_OFS_CTRL2 ? ctrl2Rd :
        ofs == `SR_OFS_BAUD ? baudQ :
        ofs == `SR_OFS_RXFINE ? fineQ[0] :
        ofs == `SR_OFS_TXFINE ? fineQ[1] : `SR_RST_BYTE;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPendQ <= 1'b0;
            wrAddrQ <= `SR_RST_BYTE;
            hrdataQ <= 32'h0;
            hreadyQ <= 1'b1;
        end else begin
            wrPendQ <= acc && hwrite;
            wrAddrQ <= ofs;
            hrdataQ <= rdAcc ? {24'h0, rdByte} : 32'h0;
            hreadyQ <= 1'b1;
        end
    end

    // status access arms the clear; a data read fires and disarms it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            statusSeenQ <= 1'b0;
        else if (accStatus)
            statusSeenQ <= 1'b1;
        else if (rdData)
            statusSeenQ <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl1Q <= `SR_RST_BYTE;
            ctrl2Q <= `SR_RST_BYTE;
            baudQ <= `SR_RST_BYTE;
            fineQ[0] <= `SR_RST_BYTE;
            fineQ[1] <= `SR_RST_BYTE;
        end else begin
            if (wrCtrl1)
                ctrl1Q <= hwdata[7:0];
            if (wrCtrl2)
                ctrl2Q <= hwdata[7:0];
            if (wrBaud)
                baudQ <= hwdata[7:0];
            if (wrRxFine)
                fineQ[0] <= hwdata[7:0];
            if (wrTxFine)
                fineQ[1] <= hwdata[7:0];
        end
    end

    // baud generation: common prescale, then per direction divider and fine
    logic [3:0] prCntQ;
    logic [1:0] bdTickQ;
    wire [3:0] prDiv =
        baudQ[7:6] == 2'd0 ? `SR_PR_SEL0 :
        baudQ[7:6] == 2'd1 ? `SR_PR_SEL1 :
        baudQ[7:6] == 2'd2 ? `SR_PR_SEL2 : `SR_PR_SEL3;
    // compare with >= so a count left above a new divisor ends at once
    wire prTick = prCntQ >= 4'(prDiv - 4'h1);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            prCntQ <= 4'h0;
        else
            prCntQ <= prTick ? 4'h0 : 4'(prCntQ + 4'h1);
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_rate
            logic [6:0] divCntQ;
            logic [7:0] fineCntQ;
            wire [2:0] sel = g == 0 ? baudQ[2:0] : baudQ[5:3];
            wire [6:0] divMax = 7'((8'h01 << sel) - 8'h01);
            wire divEnd = prTick && divCntQ >= divMax;
            wire fineEnd = fineQ[g] == 8'h00 ||
                fineCntQ >= 8'(fineQ[g] - 8'h01);
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    divCntQ <= 7'h0;
                    fineCntQ <= 8'h0;
                    bdTickQ[g] <= 1'b0;
                end else begin
                    if (prTick)
                        divCntQ <= divEnd ? 7'h0 : 7'(divCntQ + 7'h1);
                    if (divEnd)
                        fineCntQ <= fineEnd ? 8'h0 : 8'(fineCntQ + 8'h1);
                    bdTickQ[g] <= divEnd && fineEnd;
                end
            end
        end
    endgenerate

    // line input: two flip-flops before anything looks at it
    logic pinMetaQ;
    logic pinQ;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMetaQ <= 1'b1;
            pinQ <= 1'b1;
        end else begin
            pinMetaQ <= serialInPin;
            pinQ <= pinMetaQ;
        end
    end

    // bit recovery
    sr_state_e stQ;
    sr_state_e stD;
    logic [2:0] histQ;
    logic [4:0] smpCntQ;
    logic [3:0] bitIdxQ;
    logic [8:0] shiftQ;
    logic s8Q;
    logic s9Q;
    logic noiseQ;
    logic pendNoiseQ;
    logic [7:0] idleCntQ;
    logic idleArmQ;

    wire rxTick = bdTickQ[0];
    wire edgeHit = rxTick && reEn && stQ == SR_HUNT &&
        histQ == 3'b111 && !pinQ;
    wire maj = (s8Q & s9Q) | (s8Q & pinQ) | (s9Q & pinQ);
    wire split = !(s8Q == s9Q && s9Q == pinQ);
    wire at10 = rxTick && smpCntQ == `SR_SMP_10;
    wire wrap = rxTick && smpCntQ == `SR_SMP_LAST;
    wire odd357 = smpCntQ == `SR_SMP_3 || smpCntQ == `SR_SMP_5 ||
        smpCntQ == `SR_SMP_7;
    wire startNoise = rxTick && stQ == SR_START && odd357 && pinQ;
    wire falseStart = at10 && stQ == SR_START && maj;
    wire [3:0] lastBit = word9 ? `SR_LAST_BIT9 : `SR_LAST_BIT8;
    wire frameDone = at10 && stQ == SR_STOP && reEn;

    always_comb begin
        stD = stQ;
        if (!reEn)
            stD = SR_HUNT;
        else begin
            case (stQ)
                SR_HUNT: if (edgeHit) stD = SR_START;
                SR_START: begin
                    if (falseStart)
                        stD = SR_HUNT;
                    else if (wrap)
                        stD = SR_DATA;
                end
                SR_DATA: if (wrap && bitIdxQ == lastBit) stD = SR_STOP;
                SR_STOP: if (at10) stD = SR_HUNT;
                default: stD = SR_HUNT;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stQ <= SR_HUNT;
            histQ <= 3'b000;
        end else begin
            stQ <= stD;
            if (rxTick)
                histQ <= {histQ[1:0], pinQ};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            smpCntQ <= 5'd1;
            bitIdxQ <= 4'h0;
        end else if (edgeHit) begin
            smpCntQ <= `SR_SMP_FIRST;
            bitIdxQ <= 4'h0;
        end else if (rxTick && stQ != SR_HUNT) begin
            smpCntQ <= wrap ? 5'd1 : 5'(smpCntQ + 5'd1);
            if (wrap && stQ == SR_DATA)
                bitIdxQ <= 4'(bitIdxQ + 4'h1);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s8Q <= 1'b1;
            s9Q <= 1'b1;
            shiftQ <= 9'h0;
        end else begin
            if (rxTick && smpCntQ == `SR_SMP_8)
                s8Q <= pinQ;
            if (rxTick && smpCntQ == `SR_SMP_9)
                s9Q <= pinQ;
            if (at10 && stQ == SR_DATA)
                shiftQ[bitIdxQ] <= maj;
        end
    end

    // word handling
    wire [8:0] rxWord = word9 ? shiftQ : {1'b0, shiftQ[7:0]};
    wire dataMsb = word9 ? (parOn ? shiftQ[7] : shiftQ[8]) :
        (parOn ? shiftQ[6] : shiftQ[7]);
    wire parBad = parOn && ((^rxWord) != parOdd);
    wire wakeHit = frameDone && muteQ && wakeSel && dataMsb;
    wire deliver = frameDone && (!muteQ || wakeHit);
    wire load = deliver && !flagsQ[`SR_ST_FULL];
    wire [7:0] idleLim = word9 ? `SR_IDLE_LIM9 : `SR_IDLE_LIM8;
    wire idleHit = rxTick && reEn && stQ == SR_HUNT && pinQ &&
        idleCntQ == 8'(idleLim - 8'h01);
    wire idleWake = idleHit && muteQ && !wakeSel;
    wire idleSet = idleHit && !muteQ && idleArmQ;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            noiseQ <= 1'b0;
            pendNoiseQ <= 1'b0;
        end else begin
            if (edgeHit)
                noiseQ <= 1'b0;
            else if (startNoise || (at10 && split))
                noiseQ <= 1'b1;
            if (falseStart)
                pendNoiseQ <= 1'b1;
            else if (load)
                pendNoiseQ <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            idleCntQ <= 8'h0;
            idleArmQ <= 1'b1;
        end else begin
            if (!reEn || stQ != SR_HUNT || (rxTick && !pinQ))
                idleCntQ <= 8'h0;
            else if (rxTick && idleCntQ != idleLim)
                idleCntQ <= 8'(idleCntQ + 8'h01);
            if (idleSet)
                idleArmQ <= 1'b0;
            else if (load)
                idleArmQ <= 1'b1;
        end
    end

    // sticky flags: a set in the clearing cycle wins
    wire [5:0] flagSet = {
        load,
        idleSet,
        deliver && flagsQ[`SR_ST_FULL],
        load && (noiseQ || pendNoiseQ || split),
        load && !maj,
        load && parBad
    };

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flagsQ <= 6'h0;
            bufQ <= `SR_RST_BYTE;
            ninthQ <= 1'b0;
        end else begin
            flagsQ <= flagSet | (flagsQ & ~{6{clrSeq}});
            if (load) begin
                bufQ <= rxWord[7:0];
                ninthQ <= rxWord[8];
            end
        end
    end

    // mute: a control two write wins over a hardware wake
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            muteQ <= 1'b0;
        else if (wrCtrl2)
            muteQ <= hwdata[`SR_C2_MUTE];
        else if (idleWake || wakeHit)
            muteQ <= 1'b0;
    end

    wire irqD = !cpuIrqMask && !muteQ && (
        (ctrl2Q[`SR_C2_RIE] && (flagsQ[`SR_ST_FULL] || flagsQ[`SR_ST_OVR])) ||
        (ctrl2Q[`SR_C2_IDLE_IRQ_EN] && flagsQ[`SR_ST_IDLE]) ||
        (ctrl1Q[`SR_C1_PIE] && flagsQ[`SR_ST_PAR]));

    // transmit word with parity in place of the MSB
    wire [8:0] txRaw = {word9 & ctrl1Q[`SR_C1_TXNINTH], hwdata[7:0]};
    wire txPar = (word9 ? ^txRaw[7:0] : ^txRaw[6:0]) ^ parOdd;
    wire [8:0] txParWord = word9 ? {txPar, txRaw[7:0]} :
        {1'b0, txPar, txRaw[6:0]};

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqQ <= 1'b0;
            txWordQ <= 9'h0;
            txLoadQ <= 1'b0;
        end else begin
            irqQ <= irqD;
            txLoadQ <= wrData;
            if (wrData)
                txWordQ <= parOn ? txParWord : txRaw;
        end
    end

    assign hreadyout = hreadyQ;
    assign hresp = 1'b0;
    assign hrdata = hrdataQ;
    assign rxIrq = irqQ;
    assign txEnable = ctrl2Q[`SR_C2_TE];
    assign txTick = bdTickQ[1];
    assign txWord = txWordQ;
    assign txLoad = txLoadQ;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    full_load_a: assert property (load |=> flagsQ[`SR_ST_FULL] &&
        bufQ == $past(rxWord[7:0])) else $error("char not loaded");
    ovr_keep_a: assert property (deliver && flagsQ[`SR_ST_FULL] &&
        !clrSeq |=> flagsQ[`SR_ST_OVR] && $stable(bufQ))
        else $error("overrun lost buffer");
    clear_seq_a: assert property (clrSeq && !load |=>
        !flagsQ[`SR_ST_FULL]) else $error("full not cleared");
    no_clear_a: assert property (rdData && !statusSeenQ &&
        flagsQ[`SR_ST_FULL] |=> flagsQ[`SR_ST_FULL])
        else $error("full cleared without status access");
    mute_quiet_a: assert property (frameDone && muteQ && !wakeHit
        |=> $stable(flagsQ[`SR_ST_FULL])) else $error("flag set while muted");
    idle_wake_a: assert property (idleWake && !wrCtrl2 |=> !muteQ &&
        !$rose(flagsQ[`SR_ST_IDLE])) else $error("idle wake wrong");
    false_start_a: assert property (falseStart |=> stQ == SR_HUNT &&
        pendNoiseQ && !flagsQ[`SR_ST_FULL] ||
        $past(flagsQ[`SR_ST_FULL])) else $error("false start kept");
    parity_err_a: assert property (load && parBad |=>
        flagsQ[`SR_ST_PAR]) else $error("parity error missed");
    rx_irq_a: assert property (flagsQ[`SR_ST_FULL] && !muteQ &&
        ctrl2Q[`SR_C2_RIE] && !cpuIrqMask |=> rxIrq)
        else $error("receive interrupt missing");
    edge_restart_a: assert property (edgeHit |=>
        smpCntQ == `SR_SMP_FIRST && stQ == SR_START)
        else $error("sample count not restarted");
endmodule // sr_async_receiver

/* sim/sr_remote_tx.sv */
/* Remote asynchronous transmitter that drives the receive line of the block.
   Assumes callers enter its tasks just after a rising edge of sys_clk. */
`timescale 1ns/1ps
module sr_remote_tx (
    // clock
    input wire logic sys_clk,
    // serial line, idle high
    output logic lineOut
);
    initial lineOut = 1'b1;
    // start, nb bits lsb first, stop; gLen clocks of bit gBit inverted from gOff
    task automatic send(input logic [8:0] bits, input int nb, input int bc,
        input logic stopV, input int gBit, input int gOff, input int gLen);
        logic v;
        for (int i = -1; i <= nb; i++) begin
            v = (i < 0) ? 1'b0 : (i == nb) ? stopV : bits[i];
            for (int c = 0; c < bc; c++) begin
                lineOut <= (i == gBit && c >= gOff && c < gOff + gLen) ? ~v : v;
                @(posedge sys_clk);
            end
        end
        lineOut <= 1'b1;
    endtask
    // short low glitch that must not start a frame
    task automatic pulse(input int n);
        lineOut <= 1'b0;
        repeat (n) @(posedge sys_clk);
        lineOut <= 1'b1;
    endtask
endmodule // sr_remote_tx

/* sim/async_serial_receiver_baud_bench.sv */
/* Self-checking bench of the serial receive block: AHB-Lite register tasks,
   a table of frames, then corner cases. Assumes the remote transmitter model. */
`timescale 1ns/1ps
`include "sr_defines.svh"
module async_serial_receiver_baud_bench;
    typedef struct {
        logic [7:0] baud, fine, c1;
        int nb;
        logic [8:0] bits;
        logic mask;
        logic [7:0] st, data;
        logic ninth;
    } sr_row_s;
    logic sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, serialLine, cpuIrqMask;
    logic rxIrq, txEnable, txTick, txLoad;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [8:0] txWord;
    int errorCnt = 0;
    int checkCount = 0;
    int tickCnt;
    sr_row_s rows[11] = '{
        '{8'h00, 8'h00, 8'h00, 8, 9'h0A5, 1'b0, 8'h20, 8'hA5, 1'b0},
        '{8'h40, 8'h00, 8'h00, 8, 9'h03C, 1'b1, 8'h20, 8'h3C, 1'b0},
        '{8'h01, 8'h00, 8'h00, 8, 9'h081, 1'b0, 8'h20, 8'h81, 1'b0},
        '{8'h38, 8'h03, 8'h00, 8, 9'h05A, 1'b0, 8'h20, 8'h5A, 1'b0},
        '{8'hC0, 8'h00, 8'h00, 8, 9'h00F, 1'b0, 8'h20, 8'h0F, 1'b0},
        '{8'h00, 8'h00, 8'h04, 8, 9'h035, 1'b0, 8'h20, 8'h35, 1'b0},
        '{8'h00, 8'h00, 8'h05, 8, 9'h0B5, 1'b0, 8'h21, 8'hB5, 1'b0},
        '{8'h00, 8'h00, 8'h07, 8, 9'h0B5, 1'b0, 8'h20, 8'hB5, 1'b0},
        '{8'h00, 8'h00, 8'h10, 9, 9'h1C3, 1'b0, 8'h20, 8'hC3, 1'b1},
        '{8'h00, 8'h00, 8'h14, 9, 9'h107, 1'b0, 8'h20, 8'h07, 1'b1},
        '{8'h00, 8'h00, 8'h17, 9, 9'h00F, 1'b0, 8'h21, 8'h0F, 1'b0}
    };

    sr_async_receiver dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .serialInPin(serialLine), .cpuIrqMask(cpuIrqMask), .rxIrq(rxIrq),
        .txEnable(txEnable), .txTick(txTick), .txWord(txWord), .txLoad(txLoad)
    );
    sr_remote_tx line_u (.sys_clk(sys_clk), .lineOut(serialLine));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string m);
        chk8({7'h00, got}, {7'h00, exp}, m);
    endtask
    // one single-word transfer; read data taken at the edge ending the data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
        output logic [7:0] rdv);
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdv = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
        logic [7:0] x;
        bus(1'b0, a, 8'h00, x);
        chk8(x, e, m);
    endtask
    function automatic int bclk(input logic [7:0] b, input logic [7:0] f);
        int pr[4] = '{1, 3, 4, 13};
        return 16 * pr[b[7:6]] * (1 << b[2:0]) * ((f == 8'h00) ? 1 : int'(f));
    endfunction
    // baud settings change only with both directions disabled
    task automatic cfg(input logic [7:0] b, input logic [7:0] f, input logic [7:0] c1,
        input logic [7:0] c2);
        wr(`SR_OFS_CTRL2, 8'h00);
        wr(`SR_OFS_BAUD, b);
        wr(`SR_OFS_RXFINE, f);
        wr(`SR_OFS_CTRL1, c1);
        wr(`SR_OFS_CTRL2, c2);
        repeat (bclk(b, f) / 4) @(posedge sys_clk);
    endtask
    task automatic f8(input logic [7:0] d);
        line_u.send({1'b0, d}, 8, 16, 1'b1, 99, 0, 0);
    endtask
    task automatic expect_rx(input logic [7:0] st, input logic [7:0] d, input logic irq);
        chk1(rxIrq, irq, "irq level");
        rdc(`SR_OFS_STATUS, st, "status");
        rdc(`SR_OFS_DATA, d, "data");
        rdc(`SR_OFS_STATUS, 8'h00, "flags cleared");
        chk1(rxIrq, 1'b0, "irq cleared");
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        errorCnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test;
    end

    initial begin
        hsel = 1'b1;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        cpuIrqMask = 1'b0;
        reset_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        foreach (rows[k]) begin
            cfg(rows[k].baud, rows[k].fine, rows[k].c1, 8'h24);
            cpuIrqMask <= rows[k].mask;
            line_u.send(rows[k].bits, rows[k].nb, bclk(rows[k].baud, rows[k].fine),
                1'b1, 99, 0, 0);
            rdc(`SR_OFS_CTRL1, {rows[k].ninth, rows[k].c1[6:0]}, "ninth bit");
            expect_rx(rows[k].st, rows[k].data, ~rows[k].mask);
            $display("row %0d done", k);
        end
        // data read without status access must not clear
        cfg(8'h00, 8'h00, 8'h00, 8'h24);
        // the last status read of the table left the clear armed
        rdc(`SR_OFS_DATA, 8'h0F, "disarm read");
        f8(8'hA1);
        rdc(`SR_OFS_DATA, 8'hA1, "early data");
        f8(8'h5B);
        expect_rx(8'h28, 8'hA1, 1'b1);
        line_u.send(9'h00F, 8, 16, 1'b1, 3, 8, 1);
        expect_rx(8'h24, 8'h0F, 1'b1);
        line_u.pulse(6);
        repeat (40) @(posedge sys_clk);
        rdc(`SR_OFS_STATUS, 8'h00, "false start");
        f8(8'h3C);
        expect_rx(8'h24, 8'h3C, 1'b1);
        line_u.send(9'h03C, 8, 16, 1'b1, -1, 3, 3);
        expect_rx(8'h24, 8'h3C, 1'b1);
        line_u.send(9'h000, 8, 16, 1'b0, 99, 0, 0);
        expect_rx(8'h22, 8'h00, 1'b1);
        line_u.send(9'h055, 8, 16, 1'b0, 99, 0, 0);
        expect_rx(8'h22, 8'h55, 1'b1);
        $display("error test done");
        cfg(8'h00, 8'h00, 8'h00, 8'h34);
        f8(8'h11);
        expect_rx(8'h20, 8'h11, 1'b1);
        repeat (200) @(posedge sys_clk);
        expect_rx(8'h10, 8'h11, 1'b1);
        repeat (200) @(posedge sys_clk);
        rdc(`SR_OFS_STATUS, 8'h00, "idle once");
        f8(8'h66);
        expect_rx(8'h20, 8'h66, 1'b1);
        $display("idle test done");
        // no control two write until the receiver has woken
        cfg(8'h00, 8'h00, 8'h00, 8'h26);
        f8(8'h77);
        chk1(rxIrq, 1'b0, "muted irq");
        rdc(`SR_OFS_STATUS, 8'h00, "muted flags");
        repeat (200) @(posedge sys_clk);
        rdc(`SR_OFS_CTRL2, 8'h24, "idle wake");
        rdc(`SR_OFS_STATUS, 8'h00, "no idle flag");
        f8(8'h42);
        expect_rx(8'h20, 8'h42, 1'b1);
        cfg(8'h00, 8'h00, 8'h08, 8'h26);
        f8(8'h05);
        rdc(`SR_OFS_STATUS, 8'h00, "no mark");
        f8(8'h85);
        expect_rx(8'h20, 8'h85, 1'b1);
        rdc(`SR_OFS_CTRL2, 8'h24, "mark wake");
        $display("mute test done");
        cfg(8'h00, 8'h00, 8'h00, 8'h20);
        f8(8'h99);
        rdc(`SR_OFS_STATUS, 8'h00, "disabled");
        // transmit tick: divider 2, fine 2, so one pulse every 4 clocks
        wr(`SR_OFS_BAUD, 8'h08);
        wr(`SR_OFS_TXFINE, 8'h02);
        repeat (4) @(posedge sys_clk);
        tickCnt = 0;
        repeat (64) begin
            @(posedge sys_clk);
            tickCnt += int'(txTick);
        end
        chk8(8'(tickCnt), 8'd16, "tx tick rate");
        wr(`SR_OFS_CTRL1, 8'h04);
        wr(`SR_OFS_DATA, 8'hFE);
        @(posedge sys_clk);
        chk8(txWord[7:0], 8'h7E, "even tx word");
        chk1(txLoad, 1'b1, "tx load pulse");
        wr(`SR_OFS_CTRL1, 8'h06);
        wr(`SR_OFS_DATA, 8'hFE);
        @(posedge sys_clk);
        chk8(txWord[7:0], 8'hFE, "odd tx word");
        wr(`SR_OFS_CTRL2, 8'h08);
        @(posedge sys_clk);
        chk1(txEnable, 1'b1, "tx enable");
        chk1(txLoad, 1'b0, "tx load ends");
        $display("enable test done");
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk1(hreadyout, 1'b1, "ready in reset");
        chk8(txWord[7:0], 8'h00, "tx word in reset");
        chk1(txEnable, 1'b0, "tx enable in reset");
        reset_n <= 1'b1;
        @(posedge sys_clk);
        wr(8'h1C, 8'hFF);
        wr(`SR_OFS_STATUS, 8'hFF);
        for (int a = 0; a < 32; a += 4) begin
            rdc(8'(a), 8'h00, "reset value");
        end
        chk1(hresp, 1'b0, "okay response");
        $display("reset test done");
        finish_test;
    end
endmodule // async_serial_receiver_baud_bench
